// >>> common/cbf_defines.svh
// constants of the message buffer, filter and interrupt core
`ifndef CBF_DEFINES_SVH
`define CBF_DEFINES_SVH
`define CBF_MSG_BYTES     13
`define CBF_NUM_TXBUF     3
`define CBF_LOCAL_PRIORITY_FIELD_MAX      8'hFF
`define CBF_WARN_LIMIT    9'h060
`define CBF_PASSIVE_LIMIT 9'h07F
`define CBF_BUSOFF_LIMIT  9'h0FF
`define CBF_RECESSIVE     1'b1
`define CBF_TXE_RESET     3'h7
`define CBF_FMODE_SINGLE  2'h0
`define CBF_FMODE_DUAL    2'h1
`define CBF_FMODE_QUAD    2'h2
`define CBF_CFG_MASK_BASE 4
`define CBF_CFG_ACC_CTRL  8
`define CBF_CFG_MCR1      9
`define CBF_CFG_BT0       10
`define CBF_CFG_BT1       11
`define CBF_CFG_NUM       12
`define CBF_F_WAKE        0
`define CBF_F_RXWARN      1
`define CBF_F_TXWARN      2
`define CBF_F_RXPASS      3
`define CBF_F_TXPASS      4
`define CBF_F_BUSOFF      5
`define CBF_F_OVERRUN     6
`define CBF_F_RXFULL      7
`endif

// >>> common/cbf_pkg.sv
// types of the message buffer, filter and interrupt core
package cbf_pkg;
  typedef enum logic [1:0] {CBF_NORMAL, CBF_SLEEP, CBF_SOFTRST, CBF_PWRDN} cbf_mode_t;
endpackage

// >>> tb/cbf_can_node.sv
// model of the can bus: transceiver with one other node on the wire
`timescale 1ns/1ps
module cbf_can_node (
  input  wire logic clock,
  input  wire logic canTransmitPin,
  input  wire logic otherDominant,
  output logic      canReceivePin
);
  // wired-and bus, a dominant 0 from either node wins; clock kept for symmetry only
  assign canReceivePin = canTransmitPin & ~otherDominant;
endmodule

// >>> tb/tb.sv
// self-checking bench of the message buffer, filter and interrupt core
`timescale 1ns/1ps
module tb;
  import cbf_pkg::*;
  logic        clock, rst, cpuStop, cpuIntMask, softResetBit, sleepAcknowledgeFlag;
  logic        txLoadEn, arbStart, txDone, txError, txBitIn, rxStart, rxWrEn, rxEof;
  logic        rxIde, rxRtr, rxSrr, cfgWrEn, otherDominant, canReceivePin, canTransmitPin;
  logic        txSelValid, busOffState, irqWakeup, irqError, irqRx, irqTx;
  logic [10:0] intEnable;
  logic [1:0]  txLoadBuf, txSelBuf, filterHitIndicator;
  logic [3:0]  txLoadAddr, txRdAddr, rxWrAddr, fgRdAddr, cfgSel;
  logic [7:0]  txLoadData, prioWrData, rxWrData, rxErrCnt, flagClear, cfgData;
  logic [7:0]  txRdData, fgRdData, moduleControlReg1, bitTimingReg0, bitTimingReg1, rxFlagReg;
  logic [2:0]  prioWrEn, txHandOver, abortReqWr;
  logic [2:0]  txBufferEmptyFlag, abortRequestBit, abortAcknowledgeBit;
  logic [28:0] rxId;
  logic [8:0]  txErrCnt;
  cbf_mode_t   modeState;
  int          fails, n_checks;

  cbf_core DUT (.clock, .rst, .canReceivePin, .canTransmitPin, .cpuStop, .cpuIntMask,
    .softResetBit, .sleepAcknowledgeFlag, .intEnable, .txLoadEn, .txLoadBuf, .txLoadAddr,
    .txLoadData, .prioWrEn, .prioWrData, .txHandOver, .abortReqWr, .txBufferEmptyFlag,
    .abortRequestBit, .abortAcknowledgeBit, .arbStart, .txDone, .txError, .txBitIn,
    .txRdAddr, .txRdData, .txSelBuf, .txSelValid, .rxStart, .rxWrEn, .rxWrAddr, .rxWrData,
    .rxEof, .rxId, .rxIde, .rxRtr, .rxSrr, .rxErrCnt, .txErrCnt, .fgRdAddr, .fgRdData,
    .flagClear, .cfgWrEn, .cfgSel, .cfgData, .moduleControlReg1, .bitTimingReg0,
    .bitTimingReg1, .rxFlagReg, .filterHitIndicator, .busOffState, .modeState, .irqWakeup,
    .irqError, .irqRx, .irqTx);
  cbf_can_node node (.clock, .canTransmitPin, .otherDominant, .canReceivePin);

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // inputs move on falling edges only, away from the sampling edge
  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one-cycle strobes, then time for registered answers to settle
  task automatic cfg(input logic [3:0] s, input logic [7:0] d);
    cfgSel = s;
    cfgData = d;
    cfgWrEn = 1'b1;
    step(1);
    cfgWrEn = 1'b0;
    step(1);
  endtask

  task automatic clr(input logic [7:0] b);
    flagClear = b;
    step(1);
    flagClear = 8'h00;
    step(3);
  endtask

  task automatic eng(input logic [2:0] k);
    {arbStart, txDone, txError} = k;
    step(1);
    {arbStart, txDone, txError} = 3'h0;
    step(2);
  endtask

  task automatic hst(input logic [2:0] h, input logic [2:0] a);
    {txHandOver, abortReqWr} = {h, a};
    step(1);
    {txHandOver, abortReqWr} = 6'h00;
    step(2);
  endtask

  task automatic ld(input logic [1:0] b, input logic [7:0] p, input logic [7:0] d);
    txLoadBuf = b;
    txLoadData = d;
    txLoadEn = 1'b1;
    prioWrEn = 3'h1 << b;
    prioWrData = p;
    step(1);
    txLoadEn = 1'b0;
    prioWrEn = 3'h0;
    step(1);
  endtask

  // a whole received frame: start, one byte, end of frame with its id
  task automatic frame(input logic [28:0] id, input logic ide, input logic [7:0] d);
    rxStart = 1'b1;
    step(1);
    rxStart = 1'b0;
    rxWrData = d;
    rxWrEn = 1'b1;
    step(1);
    rxWrEn = 1'b0;
    rxId = id;
    rxIde = ide;
    rxEof = 1'b1;
    step(1);
    rxEof = 1'b0;
    step(3);
  endtask

  task automatic t_reset;
    chk("empty", txBufferEmptyFlag, 3'h7);
    chk("mode", modeState, CBF_NORMAL);
    chk("txpin", canTransmitPin, 1'b1);
  endtask

  task automatic t_mode;
    sleepAcknowledgeFlag = 1'b1;
    intEnable = 11'h001;
    step(3);
    chk("sleep", modeState, CBF_SLEEP);
    otherDominant = 1'b1;
    step(6);
    chk("wake", rxFlagReg[0], 1'b1);
    chk("irqwake", irqWakeup, 1'b1);
    cpuIntMask = 1'b1;
    step(3);
    chk("gmask", irqWakeup, 1'b0);
    cpuIntMask = 1'b0;
    otherDominant = 1'b0;
    softResetBit = 1'b1;
    step(3);
    chk("softrst", modeState, CBF_SOFTRST);
    sleepAcknowledgeFlag = 1'b0;
    clr(8'h01);
    chk("wakeclr", rxFlagReg[0], 1'b0);
    softResetBit = 1'b0;
    txBitIn = 1'b0;
    step(6);
    chk("normal", modeState, CBF_NORMAL);
    chk("txpin", canTransmitPin, 1'b0);
    chk("nowake", rxFlagReg[0], 1'b0);
    cpuStop = 1'b1;
    step(3);
    chk("pwrdn", modeState, CBF_PWRDN);
    chk("recess", canTransmitPin, 1'b1);
    cpuStop = 1'b0;
    txBitIn = 1'b1;
    step(3);
  endtask

  task automatic t_filter;
    intEnable = 11'h0C0;
    frame(29'h0, 1'b1, 8'h11);
    chk("extmiss", rxFlagReg[7], 1'b0);
    frame(29'h0, 1'b0, 8'h22);
    chk("full", rxFlagReg[7], 1'b1);
    chk("hit", filterHitIndicator, 2'h0);
    chk("fg", fgRdData, 8'h22);
    chk("irqrx", irqRx, 1'b1);
    clr(8'h80);
    cfg(4'h9, 8'hA5);
    step(2);
    chk("locked", moduleControlReg1, 8'h00);
    softResetBit = 1'b1;
    cfg(4'h9, 8'hA5);
    cfg(4'hA, 8'h3C);
    cfg(4'hB, 8'h5A);
    cfg(4'h8, 8'h02);
    cfg(4'h0, 8'hAA);
    cfg(4'h4, 8'h0F);
    cfg(4'h1, 8'h55);
    cfg(4'h2, 8'h55);
    step(2);
    chk("mcr1", moduleControlReg1, 8'hA5);
    chk("bt0", bitTimingReg0, 8'h3C);
    chk("bt1", bitTimingReg1, 8'h5A);
    softResetBit = 1'b0;
    step(3);
    frame({8'h33, 21'h0}, 1'b0, 8'h44);
    chk("qmiss", rxFlagReg[7], 1'b0);
    frame({8'h55, 21'h0}, 1'b0, 8'h55);
    chk("qhit", rxFlagReg[7], 1'b1);
    chk("lowhit", filterHitIndicator, 2'h1);
    frame({8'hA3, 21'h0}, 1'b0, 8'h66);
    chk("held", fgRdData, 8'h55);
    frame({8'h55, 21'h0}, 1'b0, 8'h77);
    chk("ovr", rxFlagReg[6], 1'b1);
    chk("irqerr", irqError, 1'b1);
    clr(8'h80);
    step(2);
    chk("refill", rxFlagReg[7], 1'b1);
    chk("maskhit", filterHitIndicator, 2'h0);
    chk("fg2", fgRdData, 8'h66);
    clr(8'hC0);
    chk("rxclr", rxFlagReg[7:6], 2'h0);
    softResetBit = 1'b1;
    cfg(4'h8, 8'h01);
    cfg(4'h0, 8'hA5);
    cfg(4'h1, 8'h60);
    cfg(4'h4, 8'h00);
    softResetBit = 1'b0;
    step(3);
    frame({11'h52B, 18'h0}, 1'b0, 8'h88);
    chk("dual", {rxFlagReg[7], filterHitIndicator}, 3'h4);
    clr(8'h80);
  endtask

  task automatic t_tx;
    intEnable = 11'h000;
    hst(3'h0, 3'h1);
    chk("abtempty", abortRequestBit, 3'h0);
    ld(2'h0, 8'h30, 8'hA0);
    ld(2'h1, 8'h10, 8'hA1);
    ld(2'h2, 8'h20, 8'hA2);
    hst(3'h7, 3'h0);
    chk("handover", txBufferEmptyFlag, 3'h0);
    ld(2'h1, 8'h10, 8'hFF);
    eng(3'h4);
    chk("sel", {txSelValid, txSelBuf}, 3'h5);
    chk("image", txRdData, 8'hA1);
    eng(3'h1);
    chk("retry", txSelValid, 1'b0);
    ld(2'h2, 8'h05, 8'hEE);
    eng(3'h4);
    chk("resel", {txSelValid, txSelBuf}, 3'h6);
    hst(3'h0, 3'h2);
    chk("abtack", abortAcknowledgeBit, 3'h2);
    chk("abtempty", txBufferEmptyFlag, 3'h2);
    hst(3'h0, 3'h4);
    intEnable = 11'h400;
    eng(3'h2);
    step(1);
    chk("sent", txBufferEmptyFlag, 3'h6);
    chk("sentack", abortAcknowledgeBit, 3'h2);
    chk("irqtx", irqTx, 1'b1);
    eng(3'h4);
    chk("last", {txSelValid, txSelBuf}, 3'h4);
    eng(3'h2);
    chk("alldone", txBufferEmptyFlag, 3'h7);
  endtask

  task automatic t_err;
    intEnable = 11'h03E;
    rxErrCnt = 8'h5F;
    txErrCnt = 9'h07F;
    step(3);
    chk("below", rxFlagReg[5:1], 5'h02);
    rxErrCnt = 8'h60;
    step(3);
    chk("rxwarn", rxFlagReg[1], 1'b1);
    chk("irqerr", irqError, 1'b1);
    clr(8'h02);
    chk("stuck", rxFlagReg[1], 1'b1);
    txErrCnt = 9'h080;
    step(3);
    chk("txpass", rxFlagReg[5:1], 5'h0B);
    txErrCnt = 9'h0FF;
    step(3);
    chk("nobusoff", busOffState, 1'b0);
    txErrCnt = 9'h100;
    step(3);
    chk("busoff", {busOffState, rxFlagReg[5]}, 2'h3);
    rxErrCnt = 8'h00;
    txErrCnt = 9'h000;
    step(2);
    clr(8'h3E);
    chk("errclr", {irqError, rxFlagReg}, 9'h000);
  endtask

  // stimulus from time zero, reset held five cycles
  initial begin
    {rst, cpuStop, cpuIntMask, softResetBit, sleepAcknowledgeFlag} = 5'h10;
    {txLoadEn, arbStart, txDone, txError, rxStart, rxWrEn, rxEof, cfgWrEn} = 8'h00;
    {rxIde, rxRtr, rxSrr, otherDominant, txBitIn} = 5'h01;
    {txLoadBuf, cfgSel} = 6'h00;
    {txLoadAddr, txRdAddr, rxWrAddr, fgRdAddr} = 16'hCC55;
    {txLoadData, prioWrData, rxWrData, rxErrCnt, flagClear, cfgData} = 48'h0;
    {prioWrEn, txHandOver, abortReqWr, intEnable, rxId, txErrCnt} = 58'h0;
    fails = 0;
    n_checks = 0;
    repeat (5) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    step(1);
    t_reset();
    t_mode();
    t_filter();
    t_tx();
    t_err();
    end_sim();
  end

  // watchdog well beyond the few hundred cycles the tests take
  initial begin
    #1000000;
    fails++;
    end_sim();
  end
endmodule

// >>> verilog/cbf_core.sv
// message buffers, acceptance filter, interrupt flags and mode decode
`timescale 1ns/1ps
`include "cbf_defines.svh"

// What this block does
// RULE1: three transmit buffers of 13 bytes, each with its own priority byte
// RULE2: software fills an empty buffer then clears its empty flag to send it
// RULE3: a sent buffer gets its empty flag set and raises transmit interrupt
// RULE4: among pending buffers the numerically lowest priority value goes first
// RULE5: buffer choice is redone at every arbitration, retries included
// RULE6: abort request on a buffer not in transmission sets acknowledge and empty
// RULE7: single mode compares 29 id bits plus RTR, IDE, SRR in 32 bits
// RULE8: dual mode has two 16-bit filters on standard or extended id tops
// RULE9: quad mode has four 8-bit filters on the first id byte
// RULE10: pattern bytes give expected id, set mask bits mean don't care
// RULE11: only a filter hit copies background to foreground and sets full flag
// RULE12: two-bit hit indicator names the lowest matching filter section
// RULE13: eleven sources on four vectors, local enables plus global mask
// RULE14: receive interrupt raised right after end of frame of accepted message
// RULE15: wake-up only on bus activity while sleep acknowledge and enable are set
// RULE16: warning at counter 96, passive above 127, separately for rx and tx
// RULE17: bus-off state and flag when transmit counter exceeds 255
// RULE18: flags stay pending, write one clears, ignored while condition remains
// RULE19: error counters can never be written or altered
// RULE20: control 1, bit timing and filter registers writable only in soft reset
// RULE21: cpu stop powers down, no access, transmit pin recessive
// RULE22: mode decode sleep, soft reset, normal from acknowledge and soft reset
// RULE23: third frame with both receive buffers full is discarded as overrun
module cbf_core
  import cbf_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        canReceivePin,
  output logic             canTransmitPin,
  input  wire logic        cpuStop,
  input  wire logic        cpuIntMask,
  input  wire logic        softResetBit,
  input  wire logic        sleepAcknowledgeFlag,
  input  wire logic [10:0] intEnable,
  input  wire logic        txLoadEn,
  input  wire logic [1:0]  txLoadBuf,
  input  wire logic [3:0]  txLoadAddr,
  input  wire logic [7:0]  txLoadData,
  input  wire logic [2:0]  prioWrEn,
  input  wire logic [7:0]  prioWrData,
  input  wire logic [2:0]  txHandOver,
  input  wire logic [2:0]  abortReqWr,
  output logic      [2:0]  txBufferEmptyFlag,
  output logic      [2:0]  abortRequestBit,
  output logic      [2:0]  abortAcknowledgeBit,
  input  wire logic        arbStart,
  input  wire logic        txDone,
  input  wire logic        txError,
  input  wire logic        txBitIn,
  input  wire logic [3:0]  txRdAddr,
  output logic      [7:0]  txRdData,
  output logic      [1:0]  txSelBuf,
  output logic             txSelValid,
  input  wire logic        rxStart,
  input  wire logic        rxWrEn,
  input  wire logic [3:0]  rxWrAddr,
  input  wire logic [7:0]  rxWrData,
  input  wire logic        rxEof,
  input  wire logic [28:0] rxId,
  input  wire logic        rxIde,
  input  wire logic        rxRtr,
  input  wire logic        rxSrr,
  input  wire logic [7:0]  rxErrCnt,
  input  wire logic [8:0]  txErrCnt,
  input  wire logic [3:0]  fgRdAddr,
  output logic      [7:0]  fgRdData,
  input  wire logic [7:0]  flagClear,
  input  wire logic        cfgWrEn,
  input  wire logic [3:0]  cfgSel,
  input  wire logic [7:0]  cfgData,
  output logic      [7:0]  moduleControlReg1,
  output logic      [7:0]  bitTimingReg0,
  output logic      [7:0]  bitTimingReg1,
  output logic      [7:0]  rxFlagReg,
  output logic      [1:0]  filterHitIndicator,
  output logic             busOffState,
  output cbf_mode_t        modeState,
  output logic             irqWakeup,
  output logic             irqError,
  output logic             irqRx,
  output logic             irqTx
);

  logic [7:0]  txMem [`CBF_NUM_TXBUF][`CBF_MSG_BYTES];
  logic [7:0]  prioReg [`CBF_NUM_TXBUF];
  logic [7:0]  bgMem [`CBF_MSG_BYTES];
  logic [7:0]  fgMem [`CBF_MSG_BYTES];
  logic [7:0]  cfgReg [`CBF_CFG_NUM];
  logic [2:0]  txeReg;
  logic [2:0]  abtReqReg;
  logic [2:0]  abtAckReg;
  logic        txActReg;
  logic [1:0]  txSelReg;
  logic [7:0]  flagReg;
  logic        bgFullReg;
  logic [1:0]  bgHitReg;
  logic        discardReg;
  logic        rxS1;
  logic        rxS2;
  logic        rxS3;
  cbf_mode_t   modeNow;
  logic        online;
  logic        accessOk;
  logic [1:0]  bestIdx;
  logic        anyPend;
  logic        arbGo;
  logic [2:0]  abtGrant;
  logic [31:0] frameWord;
  logic [3:0]  byteEq;
  logic [3:0]  topEq;
  logic [3:0]  secEq;
  logic [3:0]  secHit;
  logic        hitAny;
  logic [1:0]  hitIdx;
  logic        eofHit;
  logic        rxFullSet;
  logic [7:0]  setEv;
  logic [7:0]  holdCond;

  // mode decode; soft reset wins if both bits are seen together
  // RULE21: stop overrides all
  // RULE22: mode table
  always_comb begin
    if (cpuStop) begin
      modeNow = CBF_PWRDN;
    end else if (softResetBit) begin
      modeNow = CBF_SOFTRST;
    end else if (sleepAcknowledgeFlag) begin
      modeNow = CBF_SLEEP;
    end else begin
      modeNow = CBF_NORMAL;
    end
  end

  // engine events are only honoured while the module clocks would run
  assign online   = (modeNow == CBF_NORMAL);
  assign accessOk = ~cpuStop;

  always_ff @(posedge clock) begin
    if (rst) begin
      modeState <= CBF_NORMAL;
    end else begin
      modeState <= modeNow;
    end
  end

  // receive pin synchroniser, third stage only for the edge detect
  always_ff @(posedge clock) begin
    if (rst) begin
      rxS1 <= `CBF_RECESSIVE;
      rxS2 <= `CBF_RECESSIVE;
      rxS3 <= `CBF_RECESSIVE;
    end else begin
      rxS1 <= canReceivePin;
      rxS2 <= rxS1;
      rxS3 <= rxS2;
    end
  end

  // RULE21: recessive when down
  always_ff @(posedge clock) begin
    if (rst) begin
      canTransmitPin <= `CBF_RECESSIVE;
    end else begin
      canTransmitPin <= online ? txBitIn : `CBF_RECESSIVE;
    end
  end

  // RULE4: lowest value wins, ties go to the lower buffer number
  always_comb begin
    bestIdx = 2'h0;
    anyPend = 1'b0;
    for (int i = 0; i < `CBF_NUM_TXBUF; i++) begin
      if (!txeReg[i] && (!anyPend || prioReg[i] < prioReg[bestIdx])) begin
        bestIdx = i[1:0];
        anyPend = 1'b1;
      end
    end
  end

  // RULE5: choice made afresh each arbitration
  assign arbGo = arbStart & online & ~txActReg & anyPend;

  always_ff @(posedge clock) begin
    if (rst) begin
      txActReg <= 1'b0;
      txSelReg <= 2'h0;
    end else if (arbGo) begin
      txActReg <= 1'b1;
      txSelReg <= bestIdx;
    end else if ((txDone | txError) & online) begin
      txActReg <= 1'b0;
    end
  end

  // the buffer on the wire cannot be withdrawn
  always_comb begin
    for (int i = 0; i < `CBF_NUM_TXBUF; i++) begin
      abtGrant[i] = abtReqReg[i] & ~txeReg[i] & ~(txActReg & (txSelReg == i[1:0]));
    end
  end

  // empty flags, abort request and acknowledge per buffer
  always_ff @(posedge clock) begin
    if (rst) begin
      txeReg    <= `CBF_TXE_RESET;
      abtReqReg <= 3'h0;
      abtAckReg <= 3'h0;
    end else begin
      for (int i = 0; i < `CBF_NUM_TXBUF; i++) begin
        if (txActReg && txDone && online && txSelReg == i[1:0]) begin
          // RULE3: sent buffer released
          txeReg[i]    <= 1'b1;
          abtReqReg[i] <= 1'b0;
        end else if (abtGrant[i]) begin
          // RULE6: abort granted
          txeReg[i]    <= 1'b1;
          abtAckReg[i] <= 1'b1;
          abtReqReg[i] <= 1'b0;
        end else if (accessOk && txHandOver[i] && txeReg[i]) begin
          // RULE2: hand over to send
          txeReg[i]    <= 1'b0;
          abtAckReg[i] <= 1'b0;
        end else if (accessOk && abortReqWr[i] && !txeReg[i]) begin
          abtReqReg[i] <= 1'b1;
        end
      end
    end
  end

  // RULE1: message images loaded only into empty buffers, priorities written at any time cpuStop is low
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < `CBF_NUM_TXBUF; i++) begin
        prioReg[i] <= `CBF_LOCAL_PRIORITY_FIELD_MAX;
      end
    end else if (accessOk) begin
      for (int i = 0; i < `CBF_NUM_TXBUF; i++) begin
        if (prioWrEn[i]) begin
          prioReg[i] <= prioWrData;
        end
      end
      if (txLoadEn && txLoadBuf < 2'h3 && txLoadAddr < 4'hD && txeReg[txLoadBuf]) begin
        txMem[txLoadBuf][txLoadAddr] <= txLoadData;
      end
    end
  end

  // byte port for the transmit engine, one cycle latency
  always_ff @(posedge clock) begin
    if (rst) begin
      txRdData <= 8'h00;
    end else begin
      txRdData <= (txRdAddr < 4'hD) ? txMem[txSelReg][txRdAddr] : 8'h00;
    end
  end

  // RULE20: locked unless soft reset
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < `CBF_CFG_NUM; i++) begin
        cfgReg[i] <= 8'h00;
      end
    end else if (cfgWrEn && accessOk && softResetBit && cfgSel < 4'hC) begin
      cfgReg[cfgSel] <= cfgData;
    end
  end

  // RULE7: extended layout
  assign frameWord = rxIde ?
    {rxId[28:21], rxId[20:18], rxSrr, rxIde, rxId[17:15], rxId[14:7], rxId[6:0], rxRtr} :
    {rxId[28:21], rxId[20:18], rxRtr, rxIde, 3'h0, 16'h0000};

  // per-section comparators, set mask bits drop out of the compare
  // RULE10: pattern and mask
  for (genvar g = 0; g < 4; g++) begin : gSec
    assign byteEq[g] = ((frameWord[31-8*g -: 8] ^ cfgReg[g])
                        & ~cfgReg[`CBF_CFG_MASK_BASE+g]) == 8'h00;
    assign topEq[g]  = ((frameWord[31:24] ^ cfgReg[g])
                        & ~cfgReg[`CBF_CFG_MASK_BASE+g]) == 8'h00;
    assign secEq[g]  = ((frameWord[23:16] ^ cfgReg[g])
                        & ~cfgReg[`CBF_CFG_MASK_BASE+g]) == 8'h00;
  end

  // filter mode select; mode 3 closes the filter
  always_comb begin
    unique case (cfgReg[`CBF_CFG_ACC_CTRL][1:0])
      // RULE7: one 32-bit filter
      `CBF_FMODE_SINGLE: secHit = {3'h0, &byteEq};
      // RULE8: two 16-bit filters
      `CBF_FMODE_DUAL:   secHit = {2'h0, topEq[2] & secEq[3], topEq[0] & secEq[1]};
      // RULE9: four 8-bit filters
      `CBF_FMODE_QUAD:   secHit = topEq;
      default:           secHit = 4'h0;
    endcase
  end

  // RULE12: lowest section reported
  always_comb begin
    hitIdx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (secHit[i]) begin
        hitIdx = i[1:0];
      end
    end
  end

  assign hitAny = |secHit;
  assign eofHit = rxEof & online & ~discardReg & ~bgFullReg & hitAny;

  // RULE11: copy only on hit
  assign rxFullSet = ~flagReg[`CBF_F_RXFULL] & (eofHit | bgFullReg);

  // background fill, hold of a second message, and overrun discard
  always_ff @(posedge clock) begin
    if (rst) begin
      bgFullReg  <= 1'b0;
      bgHitReg   <= 2'h0;
      discardReg <= 1'b0;
    end else begin
      // RULE23: discard while both held
      if (rxStart && online) begin
        discardReg <= flagReg[`CBF_F_RXFULL] & bgFullReg;
      end else if (rxEof) begin
        discardReg <= 1'b0;
      end
      if (rxWrEn && online && !discardReg && !bgFullReg && rxWrAddr < 4'hD) begin
        bgMem[rxWrAddr] <= rxWrData;
      end
      if (eofHit && flagReg[`CBF_F_RXFULL]) begin
        bgFullReg <= 1'b1;
        bgHitReg  <= hitIdx;
      end else if (rxFullSet) begin
        bgFullReg <= 1'b0;
      end
    end
  end

  // foreground copy and hit indicator
  always_ff @(posedge clock) begin
    if (rst) begin
      filterHitIndicator <= 2'h0;
    end else if (rxFullSet) begin
      fgMem              <= bgMem;
      filterHitIndicator <= bgFullReg ? bgHitReg : hitIdx;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fgRdData <= 8'h00;
    end else begin
      fgRdData <= (fgRdAddr < 4'hD) ? fgMem[fgRdAddr] : 8'h00;
    end
  end

  // RULE19: counters enter read-only, there is no path that alters them
  // RULE16: warning and passive
  // RULE17: bus off above 255
  assign holdCond = {2'h0,
                     txErrCnt > `CBF_BUSOFF_LIMIT,
                     txErrCnt > `CBF_PASSIVE_LIMIT,
                     {1'b0, rxErrCnt} > `CBF_PASSIVE_LIMIT,
                     txErrCnt >= `CBF_WARN_LIMIT,
                     {1'b0, rxErrCnt} >= `CBF_WARN_LIMIT,
                     1'b0};

  // RULE15: dominant edge while sleep acknowledge and wake enable are set
  // RULE23: overrun flag
  assign setEv = holdCond
               | {rxFullSet, rxStart & online & flagReg[`CBF_F_RXFULL] & bgFullReg, 5'h00,
                  rxS3 & ~rxS2 & sleepAcknowledgeFlag & intEnable[`CBF_F_WAKE]};

  // RULE18: set wins, clear blocked while cause lasts
  always_ff @(posedge clock) begin
    if (rst) begin
      flagReg <= 8'h00;
    end else begin
      flagReg <= setEv | (flagReg & ~(flagClear & {8{accessOk}} & ~holdCond));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      busOffState <= 1'b0;
    end else begin
      busOffState <= txErrCnt > `CBF_BUSOFF_LIMIT;
    end
  end

  // RULE13: four vectors gated by global mask
  // RULE14: rx vector follows full flag
  always_ff @(posedge clock) begin
    if (rst) begin
      irqWakeup <= 1'b0;
      irqError  <= 1'b0;
      irqRx     <= 1'b0;
      irqTx     <= 1'b0;
    end else begin
      irqWakeup <= ~cpuIntMask & flagReg[0] & intEnable[0];
      irqError  <= ~cpuIntMask & |(flagReg[6:1] & intEnable[6:1]);
      irqRx     <= ~cpuIntMask & flagReg[7] & intEnable[7];
      irqTx     <= ~cpuIntMask & |(txeReg & intEnable[10:8]);
    end
  end

  assign txBufferEmptyFlag   = txeReg;
  assign abortRequestBit     = abtReqReg;
  assign abortAcknowledgeBit = abtAckReg;
  assign txSelBuf            = txSelReg;
  assign txSelValid          = txActReg;
  assign rxFlagReg           = flagReg;
  assign moduleControlReg1   = cfgReg[`CBF_CFG_MCR1];
  assign bitTimingReg0       = cfgReg[`CBF_CFG_BT0];
  assign bitTimingReg1       = cfgReg[`CBF_CFG_BT1];

  // helper: chosen buffer is no worse than any still pending
  logic selIsMin;
  always_comb begin
    selIsMin = 1'b1;
    for (int i = 0; i < `CBF_NUM_TXBUF; i++) begin
      if (!txeReg[i] && prioReg[i] < prioReg[txSelReg]) begin
        selIsMin = 1'b0;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sent_sets_empty_a: assert property ( // RULE3
    txActReg && txDone && online |=> txeReg[$past(txSelReg)] && !txActReg)
    else $error("sent buffer not released");
  lowest_local_priority_field_a: assert property ( // RULE4
    arbGo && !txeReg[0] && (txeReg[1] || prioReg[0] <= prioReg[1])
      && (txeReg[2] || prioReg[0] <= prioReg[2]) |=> txActReg && txSelReg == 2'h0)
    else $error("lowest value buffer not chosen");
  local_priority_field_order_a: assert property ( // RULE5
    arbGo && prioWrEn == 3'h0 && txHandOver == 3'h0 |=> selIsMin)
    else $error("higher value buffer chosen");
  abort_grant_a: assert property ( // RULE6
    abtGrant[1] |=> txeReg[1] && abtAckReg[1] && !abtReqReg[1])
    else $error("abort not granted");
  hit_copies_a: assert property ( // RULE11
    eofHit && !flagReg[`CBF_F_RXFULL] |=> flagReg[`CBF_F_RXFULL]
      && filterHitIndicator == $past(hitIdx))
    else $error("accepted frame not copied");
  miss_no_copy_a: assert property ( // RULE11
    rxEof && !hitAny && !bgFullReg && !flagReg[`CBF_F_RXFULL] |=> !flagReg[`CBF_F_RXFULL])
    else $error("rejected frame copied");
  warn_flag_a: assert property ( // RULE16
    rxErrCnt >= 8'h60 |=> flagReg[`CBF_F_RXWARN])
    else $error("rx warning missing");
  bus_off_a: assert property ( // RULE17
    txErrCnt > 9'h0FF |=> busOffState && flagReg[`CBF_F_BUSOFF])
    else $error("bus off missing");
  clear_held_a: assert property ( // RULE18
    flagReg[`CBF_F_TXPASS] && txErrCnt > 9'h07F |=> flagReg[`CBF_F_TXPASS])
    else $error("flag cleared while cause holds");
  cfg_locked_a: assert property ( // RULE20
    !softResetBit |=> $stable(cfgReg[`CBF_CFG_ACC_CTRL]))
    else $error("locked register changed");
  stop_recessive_a: assert property ( // RULE21
    cpuStop |=> canTransmitPin && modeState == CBF_PWRDN)
    else $error("transmit pin not recessive");
  overrun_a: assert property ( // RULE23
    rxStart && online && flagReg[`CBF_F_RXFULL] && bgFullReg |=> flagReg[`CBF_F_OVERRUN])
    else $error("overrun not flagged");

  sent_c:    cover property (txActReg && txDone ##1 irqTx);
  accept_c:  cover property (eofHit ##[1:3] irqRx);
  abort_c:   cover property (abtGrant != 3'h0);
  overrun_c: cover property (flagReg[`CBF_F_OVERRUN]);

endmodule
